// file: dsm_pkg.sv
// Package for the data signal modulator block.
// Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
package dsm_pkg;

  // Register byte addresses
  localparam logic [3:0] ADDR_CONTROL   = 4'h0;
  localparam logic [3:0] ADDR_MOD_SRC   = 4'h4;
  localparam logic [3:0] ADDR_HI_CARR   = 4'h8;
  localparam logic [3:0] ADDR_LO_CARR   = 4'hC;

  // Control register fields
  localparam int CTL_ENABLE_BIT   = 7;
  localparam int CTL_OUT_POL_BIT  = 4;
  localparam int CTL_OUT_STATE_BIT = 3;
  localparam int CTL_SOFT_BIT     = 0;

  // Carrier register fields
  localparam int CAR_INVERT_BIT   = 6;
  localparam int CAR_SYNC_BIT     = 5;
  localparam int SEL_MSB          = 3;

  // Writable masks and reset values
  localparam logic [7:0] CTL_WR_MASK  = 8'h91;
  localparam logic [7:0] SRC_WR_MASK  = 8'h0F;
  localparam logic [7:0] CAR_WR_MASK  = 8'h6F;
  localparam logic [7:0] CTL_RESET    = 8'h00;
  localparam logic [7:0] SRC_RESET    = 8'h00;
  localparam logic [7:0] CAR_RESET    = 8'h00;

  // Select codes
  localparam logic [3:0] MOD_SEL_SOFT = 4'h0;
  localparam logic [3:0] MOD_SEL_PIN  = 4'h1;
  localparam logic [3:0] CAR_SEL_GND  = 4'h0;
  localparam logic [3:0] CAR_SEL_NONE = 4'h9;
  localparam logic [3:0] CAR_SEL_SYS  = 4'hA;
  localparam logic [3:0] CAR_SEL_OSC  = 4'hB;

  // Pin input synchroniser depth
  localparam int SYNC_STAGES = 3;

endpackage

// file: dsm_car_if.sv
// Interface carrying one conditioned carrier between modules.
// Assumes both ends run on the block clock.
`timescale 1ns/10ps
interface dsm_car_if;
  logic       carrier;
  logic       fall;

  modport src (output carrier, output fall);
  modport dst (input  carrier, input  fall);
endinterface

// file: dsm_carrier.sv
// One carrier path: source mux, polarity, falling-edge detect.
// Assumes source bits already synchronised to clk_i.
`timescale 1ns/10ps
module dsm_carrier (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic [3:0] select_i,
  input  wire logic       invert_i,
  input  wire logic [15:0] sources_i,
  // Result
  dsm_car_if.src          car
);

  logic prev_reg;
  wire  picked = sources_i[select_i];

  // Polarity applied before edge detection
  assign car.carrier = picked ^ invert_i;
  assign car.fall    = prev_reg & ~car.carrier;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= car.carrier;
    end
  end

endmodule

// file: dsm_top.sv
// Data signal modulator: register file, source selection and mixing.
// Assumes a classic Wishbone master and asynchronous source signals.
//
// Summary of operation
// (RL1) Modulator chosen by 4-bit select field
// (RL2) High carrier chosen by 4-bit select field
// (RL3) Capture units used only in PWM mode
// (RL4) Serial data source only in SPI mode
// (RL5) Low carrier has its own select field
// (RL6) Low carrier uses the high carrier mapping
// (RL7) Modulator high passes high carrier, else low
// (RL8) Leaving synced carrier: it ends at falling edge
// (RL9) Returning to synced carrier: wait falling edge
// (RL10) High carrier sync enable at bit 5
// (RL11) Low carrier sync enable bit in register
// (RL12) High carrier inverted by bit 6
// (RL13) Low carrier inverted by its polarity bit
// (RL14) Bit 4 inverts output, idle high
// (RL15) Bit 7 enables mixing, else no output
// (RL16) Disabled forces ground carriers, soft modulator
// (RL17) Bit 3 reads current output state
// (RL18) Bit 0 is modulator when select is zero
// (RL19) Keeps running with sleep, no clock gating
// (RL20) Reset disables and clears the registers
// (RL21) Unimplemented bits read as zero
// (RL22) Inversion applied before edge detection
`timescale 1ns/10ps
module dsm_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Modulator sources, index = select code
  input  wire logic [15:0] mod_sources_i,
  // Carrier sources, index = select code
  input  wire logic [15:0] car_sources_i,
  // Modulated output
  output logic             mod_out_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Source synchronisers

  logic [15:0] mod_s1_reg, mod_s2_reg, mod_s3_reg, mod_clean_reg;
  logic [15:0] car_s1_reg, car_s2_reg, car_s3_reg, car_clean_reg;
  wire  [15:0] mod_agree = ~(mod_s2_reg ^ mod_s3_reg);
  wire  [15:0] car_agree = ~(car_s2_reg ^ car_s3_reg);
  wire  [15:0] mod_clean_next =
    (mod_agree & mod_s2_reg) | (~mod_agree & mod_clean_reg);
  wire  [15:0] car_clean_next =
    (car_agree & car_s2_reg) | (~car_agree & car_clean_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_s1_reg    <= 16'h0000;
      mod_s2_reg    <= 16'h0000;
      mod_s3_reg    <= 16'h0000;
      mod_clean_reg <= 16'h0000;
      car_s1_reg    <= 16'h0000;
      car_s2_reg    <= 16'h0000;
      car_s3_reg    <= 16'h0000;
      car_clean_reg <= 16'h0000;
    end else begin
      mod_s1_reg    <= mod_sources_i;
      mod_s2_reg    <= mod_s1_reg;
      mod_s3_reg    <= mod_s2_reg;
      mod_clean_reg <= mod_clean_next;
      car_s1_reg    <= car_sources_i;
      car_s2_reg    <= car_s1_reg;
      car_s3_reg    <= car_s2_reg;
      car_clean_reg <= car_clean_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] ctl_reg, src_reg, hi_reg, lo_reg;
  logic       out_state_reg;

  wire req      = cyc_i & stb_i;
  wire take     = req & ~ack_o;
  wire wr_lane  = take & we_i & sel_i[0];
  wire hit_ctl  = adr_i == dsm_pkg::ADDR_CONTROL;
  wire hit_src  = adr_i == dsm_pkg::ADDR_MOD_SRC;
  wire hit_hi   = adr_i == dsm_pkg::ADDR_HI_CARR;
  wire hit_lo   = adr_i == dsm_pkg::ADDR_LO_CARR;

  wire [7:0] ctl_next = dat_i[7:0] & dsm_pkg::CTL_WR_MASK;
  wire [7:0] src_next = dat_i[7:0] & dsm_pkg::SRC_WR_MASK;
  wire [7:0] car_next = dat_i[7:0] & dsm_pkg::CAR_WR_MASK;

  wire [7:0] ctl_view = ctl_reg |
    {4'h0, out_state_reg, 3'h0};                              // RL17
  wire [7:0] rd_byte =
    hit_ctl ? ctl_view :
    hit_src ? src_reg  :
    hit_hi  ? hi_reg   :
    hit_lo  ? lo_reg   : 8'h00;                               // RL21

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg <= dsm_pkg::CTL_RESET;                          // RL20
      src_reg <= dsm_pkg::SRC_RESET;
      hi_reg  <= dsm_pkg::CAR_RESET;
      lo_reg  <= dsm_pkg::CAR_RESET;
    end else if (wr_lane) begin
      if (hit_ctl) begin
        ctl_reg <= ctl_next;
      end
      if (hit_src) begin
        src_reg <= src_next;
      end
      if (hit_hi) begin
        hi_reg <= car_next;
      end
      if (hit_lo) begin
        lo_reg <= car_next;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= take;
      if (take && !we_i) begin
        dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection

  wire enable   = ctl_reg[dsm_pkg::CTL_ENABLE_BIT];            // RL15
  wire out_pol  = ctl_reg[dsm_pkg::CTL_OUT_POL_BIT];
  wire soft_bit = ctl_reg[dsm_pkg::CTL_SOFT_BIT];

  wire [3:0] mod_sel_eff = enable ?
    src_reg[dsm_pkg::SEL_MSB:0] : dsm_pkg::MOD_SEL_SOFT;       // RL16
  wire [3:0] hi_sel_eff = enable ?
    hi_reg[dsm_pkg::SEL_MSB:0] : dsm_pkg::CAR_SEL_GND;         // RL16 RL2
  wire [3:0] lo_sel_eff = enable ?
    lo_reg[dsm_pkg::SEL_MSB:0] : dsm_pkg::CAR_SEL_GND;         // RL5 RL6

  // Code 0 is the soft bit, all others the synchronised sources
  wire [15:0] mod_bank = {mod_clean_reg[15:1], soft_bit};      // RL18
  wire        mod_val  = mod_bank[mod_sel_eff];                // RL1

  // Ground and the unconnected code are forced low
  wire [15:0] car_mask = ~(16'h0001 << dsm_pkg::CAR_SEL_NONE);
  wire [15:0] car_bank = car_clean_reg & car_mask & 16'hFFFE;

  dsm_car_if hi_car ();
  dsm_car_if lo_car ();

  dsm_carrier u_hi (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .select_i  (hi_sel_eff),
    .invert_i  (hi_reg[dsm_pkg::CAR_INVERT_BIT] & enable),     // RL12 RL22
    .sources_i (car_bank),
    .car       (hi_car)
  );

  dsm_carrier u_lo (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .select_i  (lo_sel_eff),
    .invert_i  (lo_reg[dsm_pkg::CAR_INVERT_BIT] & enable),     // RL13 RL22
    .sources_i (car_bank),
    .car       (lo_car)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Carrier gating with synchronisation

  wire hi_sync = hi_reg[dsm_pkg::CAR_SYNC_BIT];                // RL10
  wire lo_sync = lo_reg[dsm_pkg::CAR_SYNC_BIT];                // RL11

  logic hi_act_reg, lo_act_reg;
  logic hi_act_next, lo_act_next;

  // While enabled, a synced carrier starts and stops only on its falling edge
  always_comb begin
    if (!enable) begin
      hi_act_next = 1'b0;
      lo_act_next = 1'b0;
    end else begin
      hi_act_next = hi_sync ?
        (hi_car.fall ? mod_val : hi_act_reg) : mod_val;        // RL8 RL9
      lo_act_next = lo_sync ?
        (lo_car.fall ? ~mod_val : lo_act_reg) : ~mod_val;      // RL8 RL9
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_act_reg <= 1'b0;
      lo_act_reg <= 1'b0;
    end else begin
      hi_act_reg <= hi_act_next;
      lo_act_reg <= lo_act_next;
    end
  end

  // Unsynced carrier follows the modulator at once
  wire hi_gate = hi_sync ? hi_act_reg : mod_val;
  wire lo_gate = lo_sync ? lo_act_reg : ~mod_val;

  wire mixed = (hi_gate & hi_car.carrier) |
               (lo_gate & lo_car.carrier);                     // RL7
  wire mod_out_next = enable & (mixed ^ out_pol);              // RL14 RL15

  ////////////////////////////////////////////////////////////////////////////
  // Output register, free running so sleep has no effect

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_out_o     <= 1'b0;                                   // RL20
      out_state_reg <= 1'b0;
    end else begin
      mod_out_o     <= mod_out_next;                           // RL19
      out_state_reg <= mod_out_next;                           // RL17
    end
  end

endmodule

// file: dsm_src_model.sv
// Source side model: peripheral outputs, pins and clocks.
// Assumes clk_i is the block clock.
`timescale 1ns/10ps
module dsm_src_model (
  // Clock
  input  wire logic        clk_i,
  // Sources
  output logic      [15:0] mod_src_o,
  output logic      [15:0] car_src_o
);
  logic [7:0] cnt_reg = 8'h00;

  always_ff @(posedge clk_i) begin
    cnt_reg <= cnt_reg + 8'h01;
  end
  // Square waves, half periods 16 to 64 cycles, always valid
  for (genvar k = 0; k < 16; k++) begin : g_src
    assign car_src_o[k] = cnt_reg[4 + k % 3] ^ (k % 2 == 1);
    assign mod_src_o[k] = cnt_reg[4 + (k + 1) % 3];
  end
endmodule

// file: dsm_chk_sva.sv
// Port checker for dsm_top.
// Assumes the bind below.
`timescale 1ns/10ps
module dsm_chk (
  // Clock, reset and bus
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  // Output
  input  wire logic        mod_out_o
);
  logic [7:0] regs_reg [4];
  logic [2:0] quiet_reg;
  wire        wr_take = cyc_i & stb_i & we_i & ~ack_o & sel_i[0]
                        & adr_i[1:0] == 2'h0;
  wire  [7:0] wr_mask = adr_i[3:2] == 2'h0 ? dsm_pkg::CTL_WR_MASK :
                        adr_i[3:2] == 2'h1 ? dsm_pkg::SRC_WR_MASK :
                        dsm_pkg::CAR_WR_MASK;
  wire  [7:0] ctl = regs_reg[0];
  wire  [7:0] rd_cmp = adr_i == 4'h0 ? dat_o[7:0] & 8'hF7 : dat_o[7:0];
  wire        plain_mix = quiet_reg == 3'h7 && regs_reg[1][3:0] == 4'h0
                          && regs_reg[2][5:0] == 6'h0
                          && regs_reg[3][5:0] == 6'h0;
  wire        mix_exp = ctl[7] & ((ctl[0] ? regs_reg[2][6] : regs_reg[3][6])
                        ^ ctl[4]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regs_reg  <= '{default: 8'h00};
      quiet_reg <= 3'h0;
    end else begin
      if (wr_take) begin
        regs_reg[adr_i[3:2]] <= dat_i[7:0] & wr_mask;
      end
      quiet_reg <= wr_take ? 3'h0 : quiet_reg + {2'h0, quiet_reg != 3'h7};
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_after_take: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_reset_clear: assert property ($fell(rst_i) |->
    !ack_o && !mod_out_o && dat_o == 32'h0) else $error("reset not clear");
  a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reg_readback: assert property (ack_o && !we_i && adr_i[1:0] == 2'h0
    |-> rd_cmp == regs_reg[adr_i[3:2]]) else $error("bad read data");
  a_unmapped_zero: assert property (ack_o && !we_i
    && adr_i[1:0] != 2'h0 |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_out_state: assert property (ack_o && !we_i && adr_i == 4'h0
    && $past(mod_out_o, 2) == $past(mod_out_o)
    |-> dat_o[3] == $past(mod_out_o)) else $error("out state wrong");
  a_disabled_low: assert property ((!ctl[7]) [*3] |-> !mod_out_o)
    else $error("output while disabled");
  a_soft_mix: assert property (plain_mix |-> mod_out_o == mix_exp)
    else $error("static mix wrong");
endmodule

bind dsm_top dsm_chk chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .mod_out_o(mod_out_o));

// file: test_data_signal_modulator.sv
// Self-checking bench for dsm_top.
// Assumes dsm_src_model drives the sources.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  error_cnt++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module test_data_signal_modulator;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  sel_i = 4'h0;
  logic [3:0]  adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack_o;
  logic        mod_out_o;
  logic [15:0] mod_src;
  logic [15:0] car_src;
  logic [7:0]  d;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          seed = 32'hcdc9;

  initial forever #50 clk_i = ~clk_i;

  dsm_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(cyc_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .mod_sources_i(mod_src), .car_sources_i(car_src),
    .mod_out_o(mod_out_o));
  dsm_src_model src (.clk_i(clk_i), .mod_src_o(mod_src), .car_src_o(car_src));

  ////////////////////////////////
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'hF;
    adr_i <= a;
    dat_i <= {24'h0, v};
    @(posedge clk_i);
    // Only the watchdog ends a wait for ack
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    we_i  <= 1'b0;
    sel_i <= 4'h0;
  endtask

  task automatic cfg(input logic [7:0] c, s, h, l);
    wb(1'b1, dsm_pkg::ADDR_MOD_SRC, s);
    wb(1'b1, dsm_pkg::ADDR_HI_CARR, h);
    wb(1'b1, dsm_pkg::ADDR_LO_CARR, l);
    wb(1'b1, dsm_pkg::ADDR_CONTROL, c);
  endtask

  // Wait for a source change, then let the path settle
  task automatic wait_edge(input int k, input logic m);
    logic v = m ? mod_src[k] : car_src[k];
    int   n = 0;
    while ((m ? mod_src[k] : car_src[k]) === v && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 200) error_cnt++;
    repeat (8) @(posedge clk_i);
  endtask

  function automatic logic exp_out(input logic m, input int k);
    if (m) return k == 0 ? 1'b1 : mod_src[k];
    return car_src[k] & k != 0 & k != 9;
  endfunction

  function automatic logic [31:0] exp_reg(input int a, input logic [7:0] v);
    logic [7:0] m;
    m = a == 0 ? dsm_pkg::CTL_WR_MASK : a == 1 ? dsm_pkg::SRC_WR_MASK :
      dsm_pkg::CAR_WR_MASK;
    return {24'h0, v & m};
  endfunction

  task automatic sync_chk(input logic [7:0] h, l, input logic ex);
    cfg(8'h81, 8'h00, h, l);
    // A falling edge after enable, then a fresh rising edge
    wait_edge(10, 1'b0);
    if (car_src[10] !== 1'b0) wait_edge(10, 1'b0);
    wait_edge(10, 1'b0);
    wb(1'b1, dsm_pkg::ADDR_CONTROL, 8'h80);
    repeat (3) @(posedge clk_i);
    `CHK("sync hold", ex, mod_out_o)
    // Next falling edge hands over, then the carrier rises again
    wait_edge(10, 1'b0);
    wait_edge(10, 1'b0);
    `CHK("sync release", ~ex, mod_out_o)
  endtask

  task automatic complete_run;
    $display("Counts: %0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      d = i == 0 ? 8'hFF : 8'($random(seed));
      for (int a = 0; a < 4; a++) begin
        wb(1'b1, 4'(a * 4), d);
        wb(1'b0, 4'(a * 4), 8'h00);
        `CHK("readback", exp_reg(a, d), rd & ~{28'h0, a == 0, 3'h0})
      end
    end
    wb(1'b0, 4'h2, 8'h00);
    `CHK("unmapped", 32'h0, rd)
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      wb(1'b0, 4'(a * 4), 8'h00);
      `CHK("reset value", 32'h0, rd)
    end
    $display("Test registers done");
    for (int k = 0; k < 16; k++) begin
      cfg(8'h81, 8'h00, 8'(k), 8'h00);
      wait_edge(k, 1'b0);
      `CHK("hi code", exp_out(1'b0, k), mod_out_o)
      cfg(8'h80, 8'h00, 8'h00, 8'(k));
      wait_edge(k, 1'b0);
      `CHK("lo code", exp_out(1'b0, k), mod_out_o)
      cfg(8'h81, 8'(k), 8'h40, 8'h00);
      wait_edge(k, 1'b1);
      `CHK("mod code", exp_out(1'b1, k), mod_out_o)
    end
    $display("Test select codes done");
    cfg(8'h90, 8'h00, 8'h00, 8'h00);
    repeat (4) @(posedge clk_i);
    `CHK("idle high", 1'b1, mod_out_o)
    cfg(8'h80, 8'h00, 8'h00, 8'h40);
    repeat (4) @(posedge clk_i);
    `CHK("lo invert", 1'b1, mod_out_o)
    $display("Test polarity done");
    sync_chk(8'h2A, 8'h00, 1'b1);
    sync_chk(8'h40, 8'h2A, 1'b0);
    $display("Test sync done");
    complete_run();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    complete_run();
  end
endmodule
